// ### irq_enable_priority_regs.sv
// Interrupt enable and priority register fragment with AXI4-Lite access
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module irq_enable_priority_regs
	import irq_regs_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Raw request pulses: [2] can rx, [1] serial2 event, [0] serial2 error
	input wire logic [irq_regs_pkg::NUM_SRC-1:0] irq_req,
	// Enabled requests passed on to arbitration
	output logic [irq_regs_pkg::NUM_SRC-1:0] irq_fwd,
	// Priority fields toward arbitration
	output logic [2:0] dma_ch1_done_prio,
	output logic [2:0] adc_done_prio,
	output logic [2:0] uart_tx_prio,
	// Level interrupt: any unmasked flag set
	output logic irq_out
);
	import irq_regs_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [15:0] enable_ff; // interrupt_enable_two
	logic [15:0] nxt_enable;
	logic [15:0] prio_ff; // interrupt_priority_three
	logic [15:0] nxt_prio;
	logic [NUM_SRC-1:0] flag_ff; // Sticky request flags
	logic [NUM_SRC-1:0] nxt_flag;
	logic [NUM_SRC-1:0] mask_ff; // Interrupt mask
	logic [NUM_SRC-1:0] nxt_mask;
	logic [NUM_SRC-1:0] fwd_ff; // Registered forwarded requests
	logic [NUM_SRC-1:0] nxt_fwd;
	logic irq_ff;
	logic nxt_irq;

	// Write channel capture
	logic aw_held_ff; // Address captured, waiting for data
	logic nxt_aw_held;
	logic [ADDR_W-1:0] aw_addr_ff;
	logic [ADDR_W-1:0] nxt_aw_addr;
	logic w_held_ff; // Data captured, waiting for address
	logic nxt_w_held;
	logic [31:0] w_data_ff;
	logic [31:0] nxt_w_data;
	logic [3:0] w_strb_ff;
	logic [3:0] nxt_w_strb;
	logic bvalid_ff;
	logic nxt_bvalid;
	logic [1:0] bresp_ff;
	logic [1:0] nxt_bresp;
	// Read channel
	logic rvalid_ff;
	logic nxt_rvalid;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [1:0] rresp_ff;
	logic [1:0] nxt_rresp;

	// Combinational helpers
	logic do_write; // Both halves present this cycle
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [15:0] wr_mask16; // Byte enables widened to a 16-bit mask

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Word-align an address so byte offsets within a word alias
	function automatic logic [7:0] word_ofs(input logic [ADDR_W-1:0] a);
		logic [7:0] w;
		w = 8'(a);
		return {w[7:2], 2'b00};
	endfunction : word_ofs

	// Merge new data into an old value under a bit mask
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
		input logic [15:0] m);
		return (old & ~m) | (nw & m);
	endfunction : merge16

	// ----------------------------------------------------------------
	// Write channel: accepts address and data in either order
	// ----------------------------------------------------------------
	// Ready only while that half is not yet held and no response waits
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;

	// Select captured or live halves
	always_comb
	begin
		wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
		wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
		wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;
		do_write = (aw_held_ff || (s_axi_awvalid && s_axi_awready))
			&& (w_held_ff || (s_axi_wvalid && s_axi_wready));
		wr_mask16 = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
	end

	// Capture halves and produce the response
	always_comb
	begin
		nxt_aw_held = aw_held_ff;
		nxt_aw_addr = aw_addr_ff;
		nxt_w_held = w_held_ff;
		nxt_w_data = w_data_ff;
		nxt_w_strb = w_strb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		if (do_write)
		begin
			// Complete the write; response one cycle later
			nxt_aw_held = 1'b0;
			nxt_w_held = 1'b0;
			nxt_bvalid = 1'b1;
			if ((word_ofs(wr_addr) == OFS_ENABLE_TWO) || (word_ofs(wr_addr) == OFS_PRIO_THREE)
				|| (word_ofs(wr_addr) == OFS_FLAGS) || (word_ofs(wr_addr) == OFS_MASK)
				|| (word_ofs(wr_addr) == OFS_FORWARD))
				nxt_bresp = RESP_OKAY;
			else
				nxt_bresp = RESP_SLVERR;
		end
		else
		begin
			// Hold whichever half arrived first
			if (s_axi_awvalid && s_axi_awready)
			begin
				nxt_aw_held = 1'b1;
				nxt_aw_addr = s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				nxt_w_held = 1'b1;
				nxt_w_data = s_axi_wdata;
				nxt_w_strb = s_axi_wstrb;
			end
		end
		if (bvalid_ff && s_axi_bready)
			nxt_bvalid = 1'b0;
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	// Writes to implemented bits only, so unused bits always read zero
	always_comb
	begin
		nxt_enable = enable_ff;
		nxt_prio = prio_ff;
		nxt_mask = mask_ff;
		nxt_flag = flag_ff;
		if (do_write)
		begin
			if (word_ofs(wr_addr) == OFS_ENABLE_TWO)
				nxt_enable = merge16(enable_ff, wr_data[15:0], wr_mask16 & ENABLE_IMPL_MASK);
			else if (word_ofs(wr_addr) == OFS_PRIO_THREE)
				nxt_prio = merge16(prio_ff, wr_data[15:0], wr_mask16 & PRIO_IMPL_MASK);
			else if (word_ofs(wr_addr) == OFS_MASK && wr_strb[0])
				nxt_mask = wr_data[NUM_SRC-1:0];
			else if (word_ofs(wr_addr) == OFS_FLAGS && wr_strb[0])
				nxt_flag = flag_ff & ~wr_data[NUM_SRC-1:0]; // Write one clears
		end
		// A request in the clearing cycle still sets the flag
		nxt_flag = nxt_flag | irq_req;
	end

	// ----------------------------------------------------------------
	// Forwarding and interrupt output
	// ----------------------------------------------------------------
	// Forward only while enabled; a disabled request is held in its flag
	always_comb
	begin
		nxt_fwd[BIT_CAN_RX_EN] = flag_ff[BIT_CAN_RX_EN] && enable_ff[BIT_CAN_RX_EN];
		nxt_fwd[BIT_SERIAL2_EVT_EN] = flag_ff[BIT_SERIAL2_EVT_EN]
			&& enable_ff[BIT_SERIAL2_EVT_EN];
		nxt_fwd[BIT_SERIAL2_ERR_EN] = flag_ff[BIT_SERIAL2_ERR_EN]
			&& enable_ff[BIT_SERIAL2_ERR_EN];
		nxt_irq = |(flag_ff & mask_ff);
	end

	// ----------------------------------------------------------------
	// Read channel: one read at a time, answer one cycle after address
	// ----------------------------------------------------------------
	assign s_axi_arready = !rvalid_ff;

	always_comb
	begin
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (s_axi_arvalid && s_axi_arready)
		begin
			nxt_rvalid = 1'b1;
			nxt_rresp = RESP_OKAY;
			if (word_ofs(s_axi_araddr) == OFS_ENABLE_TWO)
				nxt_rdata = {16'h0000, enable_ff};
			else if (word_ofs(s_axi_araddr) == OFS_PRIO_THREE)
				nxt_rdata = {16'h0000, prio_ff};
			else if (word_ofs(s_axi_araddr) == OFS_FLAGS)
				nxt_rdata = {29'h0, flag_ff};
			else if (word_ofs(s_axi_araddr) == OFS_MASK)
				nxt_rdata = {29'h0, mask_ff};
			else if (word_ofs(s_axi_araddr) == OFS_FORWARD)
				nxt_rdata = {29'h0, fwd_ff};
			else
			begin
				// Unmapped address: zero data with an error answer
				nxt_rdata = 32'h0000_0000;
				nxt_rresp = RESP_SLVERR;
			end
		end
		else if (rvalid_ff && s_axi_rready)
			nxt_rvalid = 1'b0;
	end

	// ----------------------------------------------------------------
	// Flip-flops
	// ----------------------------------------------------------------
	// Reset values are constants only
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			enable_ff <= ENABLE_RESET;
			prio_ff <= PRIO_RESET_WORD;
			flag_ff <= FLAG_RESET;
			mask_ff <= '0;
			fwd_ff <= '0;
			irq_ff <= 1'b0;
			aw_held_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_held_ff <= 1'b0;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
		end
		else
		begin
			enable_ff <= nxt_enable;
			prio_ff <= nxt_prio;
			flag_ff <= nxt_flag;
			mask_ff <= nxt_mask;
			fwd_ff <= nxt_fwd;
			irq_ff <= nxt_irq;
			aw_held_ff <= nxt_aw_held;
			aw_addr_ff <= nxt_aw_addr;
			w_held_ff <= nxt_w_held;
			w_data_ff <= nxt_w_data;
			w_strb_ff <= nxt_w_strb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign irq_fwd = fwd_ff;
	assign irq_out = irq_ff;
	assign dma_ch1_done_prio = prio_ff[DMA_CH1_PRIO_LSB +: PRIO_W];
	assign adc_done_prio = prio_ff[ADC_DONE_PRIO_LSB +: PRIO_W];
	assign uart_tx_prio = prio_ff[UART_TX_PRIO_LSB +: PRIO_W];

endmodule : irq_enable_priority_regs

// ### irq_regs_pkg.sv
// Package of offsets, field layouts and reset values for the interrupt enable/priority bank
package irq_regs_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets (one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_ENABLE_TWO = 8'h00; // interrupt_enable_two
	localparam logic [7:0] OFS_PRIO_THREE = 8'h04; // interrupt_priority_three
	localparam logic [7:0] OFS_FLAGS = 8'h08; // Sticky request flags, write one to clear
	localparam logic [7:0] OFS_MASK = 8'h0c; // Mask gating flags onto irq_out
	localparam logic [7:0] OFS_FORWARD = 8'h10; // Forwarded (enabled) requests, read only

	// ----------------------------------------------------------------
	// Enable register bit positions
	// ----------------------------------------------------------------
	localparam int BIT_SERIAL2_ERR_EN = 0;
	localparam int BIT_SERIAL2_EVT_EN = 1;
	localparam int BIT_CAN_RX_EN = 2;
	localparam logic [15:0] ENABLE_IMPL_MASK = 16'h0007; // Bits held by this fragment
	localparam logic [15:0] ENABLE_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Priority register field positions
	// ----------------------------------------------------------------
	localparam int UART_TX_PRIO_LSB = 0;
	localparam int ADC_DONE_PRIO_LSB = 4;
	localparam int DMA_CH1_PRIO_LSB = 8;
	localparam int PRIO_W = 3;
	localparam logic [2:0] PRIO_RESET = 3'h4; // Mid priority after reset
	localparam logic [15:0] PRIO_IMPL_MASK = 16'h0777;
	localparam logic [15:0] PRIO_RESET_WORD = 16'h0444;

	// ----------------------------------------------------------------
	// Event count and flag layout
	// ----------------------------------------------------------------
	localparam int NUM_SRC = 3; // can_rx, serial2 event, serial2 error
	localparam logic [NUM_SRC-1:0] FLAG_RESET = 3'h0;

	// ----------------------------------------------------------------
	// AXI4-Lite responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : irq_regs_pkg

// ### irq_enable_priority_regs_checker.sv
// Checker for the interrupt enable and priority register fragment
`timescale 1ns/1ns
module irq_enable_priority_regs_checker
	import irq_regs_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic [irq_regs_pkg::NUM_SRC-1:0] irq_req,
	input wire logic [irq_regs_pkg::NUM_SRC-1:0] irq_fwd,
	input wire logic [2:0] dma_ch1_done_prio,
	input wire logic [2:0] adc_done_prio,
	input wire logic [2:0] uart_tx_prio
);
	logic [2:0] en_ff; // Shadow of the enable bits
	logic [2:0] nxt_en; // Next shadow value
	logic wr_go; // Both write halves taken at this edge
	logic [8:0] prio; // Three priority fields side by side
	assign wr_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
	assign prio = {dma_ch1_done_prio, adc_done_prio, uart_tx_prio};
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Enable shadow
	// ----------------------------------------
	// Only follows writes whose halves arrive together, as the bench offers them
	always_comb
	begin
		nxt_en = en_ff;
		if (wr_go && s_axi_awaddr[7:2] == OFS_ENABLE_TWO[7:2] && s_axi_wstrb[0])
			nxt_en = s_axi_wdata[2:0];
	end
	// Register the shadow
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			en_ff <= 3'h0;
		else
			en_ff <= nxt_en;
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_can_fwd: assert property (irq_req[2] && en_ff[2] ##1 en_ff[2] |-> ##1 irq_fwd[2])
		else $error("can receive request not forwarded");
	a_event_fwd: assert property (irq_req[1] && en_ff[1] ##1 en_ff[1] |-> ##1 irq_fwd[1])
		else $error("serial event request not forwarded");
	a_error_fwd: assert property (irq_req[0] && en_ff[0] ##1 en_ff[0] |-> ##1 irq_fwd[0])
		else $error("serial error request not forwarded");
	a_block_disabled: assert property ((irq_fwd & ~$past(en_ff)) == 3'h0)
		else $error("request forwarded while disabled");
	a_prio_write: assert property (wr_go && s_axi_awaddr[7:2] == OFS_PRIO_THREE[7:2]
		&& s_axi_wstrb[1:0] == 2'h3 |=> prio == {$past(s_axi_wdata[10:8]),
		$past(s_axi_wdata[6:4]), $past(s_axi_wdata[2:0])})
		else $error("priority fields differ from written word");
	a_prio_reset: assert property ($rose(rst_n) |-> prio == 9'h124)
		else $error("priority fields not at reset value");
	a_unused_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hffff_f888) == 32'h0)
		else $error("unimplemented read bits not zero");
	cover property (wr_go && s_axi_awaddr[7:2] == OFS_PRIO_THREE[7:2]);
	cover property (|irq_fwd);
	cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : irq_enable_priority_regs_checker
bind irq_enable_priority_regs irq_enable_priority_regs_checker #(.ADDR_W(ADDR_W)) chk_i (
	.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.irq_req(irq_req), .irq_fwd(irq_fwd), .dma_ch1_done_prio(dma_ch1_done_prio),
	.adc_done_prio(adc_done_prio), .uart_tx_prio(uart_tx_prio));

// ### testbench.sv
// Self-checking bench for the interrupt enable and priority register fragment
`timescale 1ns/1ns
module testbench;
	import irq_regs_pkg::*;
	logic sys_clk = 1'b0; // 20 MHz system clock
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [2:0] irq_req = 3'h0;
	logic awready, wready, bvalid, arready, rvalid, irq_out;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] irq_fwd, dma_p, adc_p, uart_p;
	int fail_count = 0;
	int comparisons = 0;
	irq_enable_priority_regs irq_enable_priority_regs_i (.sys_clk(sys_clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq_req(irq_req), .irq_fwd(irq_fwd), .dma_ch1_done_prio(dma_p),
		.adc_done_prio(adc_p), .uart_tx_prio(uart_p), .irq_out(irq_out));
	always #25 sys_clk = ~sys_clk;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic stop_test;
		if (fail_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			$display("Error %s expected %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask : check
	// Handshakes are judged on the negedge so the edge's own updates never race the bench
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_hit, w_hit, b_hit;
		logic [1:0] resp;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b_hit = 1'b0;
		for (int n = 0; n < 40 && !b_hit; n++)
		begin
			@(negedge sys_clk);
			aw_hit = awvalid & awready;
			w_hit = wvalid & wready;
			b_hit = bvalid & bready;
			resp = bresp;
			@(posedge sys_clk);
			if (aw_hit)
				awvalid <= 1'b0;
			if (w_hit)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (!b_hit)
		begin
			// Timed out: counts as a mismatch and ends the run
			fail_count++;
			stop_test();
		end
		else
			check("bresp", {30'h0, resp}, {30'h0, er});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic ar_hit, r_hit;
		logic [31:0] d;
		logic [1:0] resp;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r_hit = 1'b0;
		for (int n = 0; n < 40 && !r_hit; n++)
		begin
			@(negedge sys_clk);
			ar_hit = arvalid & arready;
			r_hit = rvalid & rready;
			d = rdata;
			resp = rresp;
			@(posedge sys_clk);
			if (ar_hit)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		if (!r_hit)
		begin
			// Timed out: counts as a mismatch and ends the run
			fail_count++;
			stop_test();
		end
		else
		begin
			check("rdata", d, exp);
			check("rresp", {30'h0, resp}, {30'h0, er});
		end
	endtask : rd
	// One request cycle on every source, then settle past the forwarding delay
	task automatic pulse;
		@(posedge sys_clk);
		irq_req <= 3'h7;
		@(posedge sys_clk);
		irq_req <= 3'h0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : pulse
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		@(negedge sys_clk);
		check("prio ports", {23'h0, dma_p, adc_p, uart_p}, 32'h0000_0124);
		rd(OFS_PRIO_THREE, 32'h0000_0444, RESP_OKAY);
		rd(OFS_ENABLE_TWO, 32'h0, RESP_OKAY);
	endtask : t_reset
	task automatic t_prio;
		wr(OFS_PRIO_THREE, 32'hffff_ffff, RESP_OKAY);
		rd(OFS_PRIO_THREE, 32'h0000_0777, RESP_OKAY);
		wr(OFS_PRIO_THREE, 32'h0000_0125, RESP_OKAY);
		rd(OFS_PRIO_THREE, 32'h0000_0125, RESP_OKAY);
		check("prio ports", {23'h0, dma_p, adc_p, uart_p}, 32'h0000_0055);
	endtask : t_prio
	// Unmapped access is refused and must leave the priorities alone
	task automatic t_unmapped;
		wr(8'h20, 32'hffff_ffff, RESP_SLVERR);
		rd(8'h20, 32'h0, RESP_SLVERR);
		rd(OFS_PRIO_THREE, 32'h0000_0125, RESP_OKAY);
	endtask : t_unmapped
	// Step 3 writes an unimplemented bit, so no source is enabled there
	task automatic t_enable;
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_ENABLE_TWO, 32'h1 << i, RESP_OKAY);
			rd(OFS_ENABLE_TWO, (32'h1 << i) & 32'h7, RESP_OKAY);
			pulse();
			check("irq_fwd", {29'h0, irq_fwd}, (32'h1 << i) & 32'h7);
			rd(OFS_FORWARD, (32'h1 << i) & 32'h7, RESP_OKAY);
			rd(OFS_FLAGS, 32'h7, RESP_OKAY);
			wr(OFS_FLAGS, 32'h7, RESP_OKAY);
			// The forward register settles one edge after the clear lands
			@(negedge sys_clk);
			check("irq_fwd cleared", {29'h0, irq_fwd}, 32'h0);
		end
	endtask : t_enable
	task automatic t_irq;
		wr(OFS_MASK, 32'h4, RESP_OKAY);
		pulse();
		check("irq_out", {31'h0, irq_out}, 32'h1);
		wr(OFS_MASK, 32'h0, RESP_OKAY);
		// The interrupt line is registered, so look after the launching edge
		@(negedge sys_clk);
		check("irq_out masked", {31'h0, irq_out}, 32'h0);
		wr(OFS_FLAGS, 32'h7, RESP_OKAY);
		wr(OFS_MASK, 32'h4, RESP_OKAY);
		@(negedge sys_clk);
		check("irq_out cleared", {31'h0, irq_out}, 32'h0);
	endtask : t_irq
	initial
	begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_prio();
		t_unmapped();
		t_enable();
		t_irq();
		stop_test();
	end
endmodule : testbench
